// *** itd_pkg.sv ***
// Shared constants and types for the instruction timing decoder core.
// Assumes a 16-bit program word and a byte-wide data memory of 1024 bytes.
package itd_pkg;

  // Instruction cycle phases, four system clocks per cycle
  typedef enum logic [1:0] {
    ITD_PH0 = 2'b00,
    ITD_PH1 = 2'b01,
    ITD_PH2 = 2'b10,
    ITD_PH3 = 2'b11
  } itd_phase_e;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PHASES        = 4;

  localparam int unsigned PC_W    = 11;
  localparam int unsigned DM_AW   = 10;
  localparam int unsigned STACK_D = 8;
  localparam int unsigned SP_W    = 3;

  // Reset values and increment steps
  localparam logic [PC_W-1:0] PC_RESET  = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP   = 11'h001;
  localparam logic [7:0]      ACC_RESET = 8'h00;
  localparam logic [15:0]     IR_RESET  = 16'h0000;
  localparam logic [SP_W-1:0] SP_RESET  = 3'h0;
  localparam logic [SP_W-1:0] SP_STEP   = 3'h1;

  // Fixed addresses
  localparam logic [1:0] DM_SECTOR0       = 2'h0;
  localparam logic [7:0] PC_LOW_BYTE_ADDR = 8'h06;
  localparam logic [2:0] TBL_PAGE         = 3'h7;

  // Instruction word fields
  localparam int unsigned OPC_MSB  = 15;
  localparam int unsigned OPC_LSB  = 11;
  localparam int unsigned DEST_BIT = 10;
  localparam int unsigned IMM_BIT  = 9;
  localparam int unsigned BIT_MSB  = 10;
  localparam int unsigned BIT_LSB  = 8;

  typedef enum logic [4:0] {
    OP_NOP           = 5'h00,
    OP_XFER_A_M      = 5'h01,
    OP_XFER_M_A      = 5'h02,
    OP_XFER_A_X      = 5'h03,
    OP_ADD           = 5'h04,
    OP_ADC           = 5'h05,
    OP_SUB           = 5'h06,
    OP_SBC           = 5'h07,
    OP_AND           = 5'h08,
    OP_OR            = 5'h09,
    OP_XOR           = 5'h0a,
    OP_COMPLEMENT    = 5'h0b,
    OP_ADD_ONE       = 5'h0c,
    OP_SUB_ONE       = 5'h0d,
    OP_ROT_RIGHT     = 5'h0e,
    OP_ROT_LEFT      = 5'h0f,
    OP_ROT_RIGHT_C   = 5'h10,
    OP_ROT_LEFT_C    = 5'h11,
    OP_BIT_CLEAR     = 5'h12,
    OP_BIT_SET       = 5'h13,
    OP_SKIP_ZERO     = 5'h14,
    OP_SKIP_NZERO    = 5'h15,
    OP_SKIP_BZERO    = 5'h16,
    OP_SKIP_BNZERO   = 5'h17,
    OP_UNCOND_BRANCH = 5'h18,
    OP_CALL          = 5'h19,
    OP_SUB_EXIT      = 5'h1a,
    OP_INT_EXIT      = 5'h1b,
    OP_TABLE_READ    = 5'h1c,
    OP_POWER_DOWN    = 5'h1d
  } itd_op_e;

endpackage : itd_pkg

// *** itd_alu_if.sv ***
// Carrier between the sequencing core and its byte ALU.
// Assumes the ALU is purely combinational.
`timescale 1ns/1ps
interface itd_alu_if;
  import itd_pkg::*;
  itd_op_e    op;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [2:0] bit_idx;
  logic [7:0] result;
  logic       cout;
  logic       zero;

  modport core (output op, a, b, cin, bit_idx, input result, cout, zero);
  modport alu  (input op, a, b, cin, bit_idx, output result, cout, zero);
endinterface : itd_alu_if

// *** itd_alu.sv ***
// Combinational byte ALU for the instruction timing decoder core.
// Assumes the core latches results only at the last phase of a cycle.
`timescale 1ns/1ps
module itd_alu
  import itd_pkg::*;
(
  itd_alu_if.alu bus  // Operands in, result and flags out
);

  logic [8:0] wide;
  logic [7:0] mask;

  always_comb begin
    wide       = 9'h000;
    // bit index selects bit 0 to 7
    mask       = 8'h01 << bus.bit_idx;
    bus.result = bus.b;
    bus.cout   = bus.cin;
    case (bus.op)
      OP_XFER_M_A:  bus.result = bus.a;
      OP_XFER_A_M,
      OP_XFER_A_X:  bus.result = bus.b;
      OP_ADD, OP_ADC: begin
        wide       = {1'b0, bus.a} + {1'b0, bus.b}
                   + {8'h00, (bus.op == OP_ADC) & bus.cin};
        bus.result = wide[7:0];
        bus.cout   = wide[8];
      end
      OP_SUB, OP_SBC: begin
        wide       = {1'b0, bus.a} - {1'b0, bus.b}
                   - {8'h00, (bus.op == OP_SBC) & ~bus.cin};
        bus.result = wide[7:0];
        bus.cout   = ~wide[8];
      end
      OP_AND:        bus.result = bus.a & bus.b;
      OP_OR:         bus.result = bus.a | bus.b;
      OP_XOR:        bus.result = bus.a ^ bus.b;
      OP_COMPLEMENT: bus.result = ~bus.b;
      OP_ADD_ONE:    bus.result = bus.b + 8'h01;
      OP_SUB_ONE:    bus.result = bus.b - 8'h01;
      OP_ROT_RIGHT:  bus.result = {bus.b[0], bus.b[7:1]};
      OP_ROT_LEFT:   bus.result = {bus.b[6:0], bus.b[7]};
      OP_ROT_RIGHT_C: begin
        bus.result = {bus.cin, bus.b[7:1]};
        bus.cout   = bus.b[0];
      end
      OP_ROT_LEFT_C: begin
        bus.result = {bus.b[6:0], bus.cin};
        bus.cout   = bus.b[7];
      end
      OP_BIT_CLEAR:  bus.result = bus.b & ~mask;
      OP_BIT_SET:    bus.result = bus.b | mask;
      default:       bus.result = bus.b;
    endcase
    bus.zero = (bus.result == 8'h00);
  end

endmodule : itd_alu

// *** itd_core.sv ***
// Instruction sequencing and decode core, 8-bit accumulator machine.
// Assumes program memory answers prog_addr within three clocks and data
// memory answers dm_addr within two clocks; dm writes occur at the next edge.
// Function
// - Instruction cycle is four system clocks
// - Branches, calls, returns, table reads take two
// - Writing PC low byte adds a cycle
// - Taken skip costs one extra cycle
// - Zero logic result sets zero flag
// - Accumulator is the working register
// - Carry on overflow, borrow via carry
// - Increment and decrement change by one
// - Rotate one bit, circular or through carry
// - Call saves return, exit resumes there
// - Jump loads target, saves nothing
// - Conditional test skips or executes next
// - Bit set/clear is read-modify-write
// - Table read fetches program memory data
// - Dedicated power-down instruction
// - Direct addressing limited to sector 0
// - Bit index selects positions 0 to 7
// - Transfers both ways, immediate to accumulator
// - Interrupt exit sets enable, plain keeps it
`timescale 1ns/1ps
module itd_core
  import itd_pkg::*;
(
  input  wire logic             clk,               // System clock, 50 MHz
  input  wire logic             resetn,            // Async reset, active low
  output logic      [PC_W-1:0]  prog_addr,         // Program memory address
  input  wire logic [15:0]      prog_data,         // Program memory word
  output logic      [DM_AW-1:0] dm_addr,           // Data memory address
  input  wire logic [7:0]       dm_rdata,          // Data memory read byte
  output logic      [7:0]       dm_wdata,          // Data memory write byte
  output logic                  dm_we,             // Data memory write strobe
  input  wire logic             wake_req,          // Leave power-down
  output logic      [7:0]       acc_value,         // Accumulator
  output logic                  carry_flag,        // Carry flag
  output logic                  zero_flag,         // Zero flag
  output logic                  global_irq_enable, // Global interrupt enable
  output logic                  halted,            // Power-down state
  output logic      [7:0]       tbl_high_byte,     // Upper byte of table word
  output itd_phase_e            cycle_phase,       // Current clock phase
  output logic                  instr_done         // One clock per executed op
);

  itd_alu_if alu_bus ();

  itd_alu u_alu (
    .bus (alu_bus.alu)
  );

  // Sequencer state
  logic [PC_W-1:0] pc;
  logic [15:0]     ir;
  logic            ir_valid;
  logic [SP_W-1:0] sp;
  logic [PC_W-1:0] stack [STACK_D];
  logic [7:0]      operand;
  logic            tbl_pending;
  logic [7:0]      tbl_dest;

  logic [PC_W-1:0] next_pc;
  logic [15:0]     next_ir;
  logic            next_ir_valid;
  logic [SP_W-1:0] next_sp;
  logic [PC_W-1:0] next_stack [STACK_D];
  logic [7:0]      next_operand;
  logic            next_tbl_pending;
  logic [7:0]      next_tbl_dest;
  logic [PC_W-1:0] next_prog_addr;
  logic [DM_AW-1:0] next_dm_addr;
  logic [7:0]      next_dm_wdata;
  logic            next_dm_we;
  logic [7:0]      next_acc;
  logic            next_carry;
  logic            next_zero;
  logic            next_gie;
  logic            next_halted;
  logic [7:0]      next_tbl_high;
  logic            next_instr_done;
  itd_phase_e      next_phase;

  // Decode of the instruction held in ir
  itd_op_e         op;
  logic            dest_mem;
  logic            use_imm;
  logic [2:0]      bit_idx;
  logic            exec_now;
  logic            alu_group;
  logic            imm_capable;
  logic            wr_acc;
  logic            wr_mem;
  logic            upd_z;
  logic            upd_c;
  logic            skip_hit;
  logic            pcl_hit;

  assign op          = itd_op_e'(ir[OPC_MSB:OPC_LSB]);
  assign dest_mem    = ir[DEST_BIT];
  assign use_imm     = ir[IMM_BIT];
  assign bit_idx     = ir[BIT_MSB:BIT_LSB];
  // Execution only at the last phase; a halted or table cycle executes nothing
  assign exec_now    = (cycle_phase == ITD_PH3) && ir_valid && !halted && !tbl_pending;
  assign alu_group   = (op >= OP_ADD) && (op <= OP_ROT_LEFT_C);
  assign imm_capable = (op >= OP_ADD) && (op <= OP_XOR) && use_imm;
  assign wr_acc      = (op == OP_XFER_A_M) || (op == OP_XFER_A_X)
                     || (alu_group && (!dest_mem || imm_capable));
  assign wr_mem      = (op == OP_XFER_M_A) || (op == OP_BIT_CLEAR) || (op == OP_BIT_SET)
                     || (alu_group && dest_mem && !imm_capable);
  assign upd_z       = (op >= OP_ADD) && (op <= OP_SUB_ONE);
  assign upd_c       = ((op >= OP_ADD) && (op <= OP_SBC))
                     || (op == OP_ROT_RIGHT_C) || (op == OP_ROT_LEFT_C);
  assign pcl_hit     = wr_mem && (ir[7:0] == PC_LOW_BYTE_ADDR);

  always_comb begin
    case (op)
      OP_SKIP_ZERO:   skip_hit = (operand == 8'h00);
      OP_SKIP_NZERO:  skip_hit = (operand != 8'h00);
      OP_SKIP_BZERO:  skip_hit = !operand[bit_idx];
      OP_SKIP_BNZERO: skip_hit = operand[bit_idx];
      default:        skip_hit = 1'b0;
    endcase
  end

  assign alu_bus.op      = op;
  assign alu_bus.a       = acc_value;
  assign alu_bus.b       = (imm_capable || op == OP_XFER_A_X) ? ir[7:0] : operand;
  assign alu_bus.cin     = carry_flag;
  assign alu_bus.bit_idx = bit_idx;

  always_comb begin
    case (cycle_phase)
      ITD_PH0: next_phase = ITD_PH1;
      ITD_PH1: next_phase = ITD_PH2;
      ITD_PH2: next_phase = ITD_PH3;
      ITD_PH3: next_phase = ITD_PH0;
      default: next_phase = ITD_PH0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cycle_phase <= ITD_PH0;
    end else begin
      cycle_phase <= next_phase;
    end
  end

  always_comb begin
    next_pc          = pc;
    next_ir          = ir;
    next_ir_valid    = ir_valid;
    next_sp          = sp;
    next_stack       = stack;
    next_operand     = operand;
    next_tbl_pending = tbl_pending;
    next_tbl_dest    = tbl_dest;
    next_prog_addr   = prog_addr;
    next_dm_addr     = dm_addr;
    next_dm_wdata    = dm_wdata;
    next_dm_we       = 1'b0;
    next_acc         = acc_value;
    next_carry       = carry_flag;
    next_zero        = zero_flag;
    next_gie         = global_irq_enable;
    next_halted      = halted && !wake_req;
    next_tbl_high    = tbl_high_byte;
    next_instr_done  = 1'b0;
    case (cycle_phase)
      ITD_PH0: begin
        next_prog_addr = tbl_pending ? {TBL_PAGE, acc_value} : pc;
        next_dm_addr   = {DM_SECTOR0, tbl_pending ? tbl_dest : ir[7:0]};
      end
      ITD_PH1: begin
        next_operand = operand;
      end
      ITD_PH2: begin
        next_operand = dm_rdata;
      end
      ITD_PH3: begin
        if (tbl_pending) begin
          next_dm_we       = 1'b1;
          next_dm_wdata    = prog_data[7:0];
          next_tbl_high    = prog_data[15:8];
          next_tbl_pending = 1'b0;
        end else if (!halted) begin
          next_ir       = prog_data;
          next_ir_valid = 1'b1;
          next_pc       = pc + PC_STEP;
          if (ir_valid) begin
            next_instr_done = 1'b1;
            if (wr_acc) begin
              next_acc = alu_bus.result;
            end
            if (upd_z) begin
              next_zero = alu_bus.zero;
            end
            if (upd_c) begin
              next_carry = alu_bus.cout;
            end
            if (wr_mem) begin
              if (pcl_hit) begin
                next_pc       = {pc[PC_W-1:8], alu_bus.result};
                next_ir_valid = 1'b0;
              end else begin
                next_dm_we    = 1'b1;
                next_dm_wdata = alu_bus.result;
              end
            end
            if (skip_hit) begin
              next_ir_valid = 1'b0;
            end
            case (op)
              OP_UNCOND_BRANCH: begin
                next_pc       = ir[PC_W-1:0];
                next_ir_valid = 1'b0;
              end
              OP_CALL: begin
                next_stack[sp] = pc;
                next_sp        = sp + SP_STEP;
                next_pc        = ir[PC_W-1:0];
                next_ir_valid  = 1'b0;
              end
              OP_SUB_EXIT, OP_INT_EXIT: begin
                next_sp       = sp - SP_STEP;
                next_pc       = stack[sp - SP_STEP];
                next_ir_valid = 1'b0;
                if (op == OP_INT_EXIT) begin
                  next_gie = 1'b1;
                end
              end
              OP_TABLE_READ: begin
                next_tbl_pending = 1'b1;
                next_tbl_dest    = ir[7:0];
              end
              OP_POWER_DOWN: begin
                next_halted = 1'b1;
              end
              default: begin
                next_sp = sp;
              end
            endcase
          end
        end
      end
      default: begin
        next_operand = operand;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc                <= PC_RESET;
      ir                <= IR_RESET;
      ir_valid          <= 1'b0;
      sp                <= SP_RESET;
      for (int i = 0; i < STACK_D; i++) begin
        stack[i] <= PC_RESET;
      end
      operand           <= ACC_RESET;
      tbl_pending       <= 1'b0;
      tbl_dest          <= ACC_RESET;
      prog_addr         <= PC_RESET;
      dm_addr           <= {DM_SECTOR0, ACC_RESET};
      dm_wdata          <= ACC_RESET;
      dm_we             <= 1'b0;
      acc_value         <= ACC_RESET;
      carry_flag        <= 1'b0;
      zero_flag         <= 1'b0;
      global_irq_enable <= 1'b0;
      halted            <= 1'b0;
      tbl_high_byte     <= ACC_RESET;
      instr_done        <= 1'b0;
    end else begin
      pc                <= next_pc;
      ir                <= next_ir;
      ir_valid          <= next_ir_valid;
      sp                <= next_sp;
      stack             <= next_stack;
      operand           <= next_operand;
      tbl_pending       <= next_tbl_pending;
      tbl_dest          <= next_tbl_dest;
      prog_addr         <= next_prog_addr;
      dm_addr           <= next_dm_addr;
      dm_wdata          <= next_dm_wdata;
      dm_we             <= next_dm_we;
      acc_value         <= next_acc;
      carry_flag        <= next_carry;
      zero_flag         <= next_zero;
      global_irq_enable <= next_gie;
      halted            <= next_halted;
      tbl_high_byte     <= next_tbl_high;
      instr_done        <= next_instr_done;
    end
  end

  // Checks on the sequencing behaviour
  a_phase_wrap: assert property (@(posedge clk) disable iff (!resetn)
    (cycle_phase == ITD_PH3) |=> (cycle_phase == ITD_PH0) ##3 (cycle_phase == ITD_PH3))
    else $error("phase did not return after four clocks");

  a_phase_start: assert property (@(posedge clk)
    $rose(resetn) |-> (cycle_phase == ITD_PH0))
    else $error("phase not at first phase after reset");

  a_branch_flush: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_UNCOND_BRANCH) |=>
      (!ir_valid && pc == $past(ir[PC_W-1:0]) && sp == $past(sp)))
    else $error("jump did not load target or touched stack");

  a_call_save: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_CALL) |=>
      (stack[$past(sp)] == $past(pc) && sp == $past(sp) + SP_STEP && !ir_valid))
    else $error("call did not save return address");

  a_int_exit: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_INT_EXIT) |=> (global_irq_enable && pc == stack[sp]))
    else $error("interrupt exit did not restore or enable");

  a_plain_exit: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_SUB_EXIT) |=>
      (global_irq_enable == $past(global_irq_enable) && pc == stack[sp]))
    else $error("plain exit changed enable or address");

  a_skip_cost: assert property (@(posedge clk) disable iff (!resetn)
    exec_now |=> (ir_valid == !$past(skip_hit || pcl_hit || op == OP_UNCOND_BRANCH
      || op == OP_CALL || op == OP_SUB_EXIT || op == OP_INT_EXIT)))
    else $error("fetch kept or dropped wrongly");

  a_logic_zero: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op >= OP_AND && op <= OP_COMPLEMENT && alu_bus.result == 8'h00)
      |=> zero_flag)
    else $error("zero flag not set on zero logic result");

  a_pcl_jump: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && pcl_hit) |=> (!ir_valid && !dm_we && pc[7:0] == $past(alu_bus.result)))
    else $error("PC low byte write did not jump");

  a_bit_rmw: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_BIT_SET) |=>
      (dm_we && dm_wdata == ($past(operand) | (8'h01 << $past(bit_idx)))))
    else $error("bit set changed other bits");

  a_add_carry: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_ADD) |=>
      (carry_flag == (({1'b0, $past(acc_value)} + {1'b0, $past(alu_bus.b)}) > 9'h0ff)))
    else $error("carry wrong after add");

  a_table_fetch: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_TABLE_READ) |=> ##1
      (prog_addr == {TBL_PAGE, acc_value}) ##3 (dm_we && dm_wdata == $past(prog_data[7:0])))
    else $error("table read did not fetch and store");

  a_power_down: assert property (@(posedge clk) disable iff (!resetn)
    (exec_now && op == OP_POWER_DOWN && !wake_req) |=> halted)
    else $error("power-down not entered");

  a_sector_zero: assert property (@(posedge clk) disable iff (!resetn)
    dm_addr[DM_AW-1:8] == DM_SECTOR0)
    else $error("data address left sector 0");

endmodule : itd_core

// *** itd_mem_model.sv ***
// Behavioural program and data memory facing the decoder core.
// Assumes the bench preloads both arrays before reset is released.
`timescale 1ns/1ps
module itd_mem_model
  import itd_pkg::*;
(
  input  wire logic             clk,       // System clock
  input  wire logic [PC_W-1:0]  prog_addr, // Fetch address
  output logic      [15:0]      prog_data, // Fetched word
  input  wire logic [DM_AW-1:0] dm_addr,   // Data address
  output logic      [7:0]       dm_rdata,  // Read byte
  input  wire logic [7:0]       dm_wdata,  // Write byte
  input  wire logic             dm_we      // Write strobe
);
  logic [15:0] prog [2**PC_W];
  logic [7:0]  data [2**DM_AW];

  // Zero-wait answers, well inside the sampling phase
  assign prog_data = prog[prog_addr];
  assign dm_rdata  = data[dm_addr];

  always @(posedge clk) begin
    if (dm_we === 1'b1) begin
      data[dm_addr] <= dm_wdata;
    end
  end
endmodule : itd_mem_model

// *** itd_core_bench.sv ***
// Self-checking bench for the decoder core: one program run, then wake.
// Assumes the memory model above and the core's four-clock cycle.
`timescale 1ns/1ps
module itd_core_bench;
  import itd_pkg::*;
  logic              clk, resetn, wake_req, dm_we, carry_flag, zero_flag;
  logic              irq_en, halted, instr_done;
  logic [PC_W-1:0]   prog_addr;
  logic [15:0]       prog_data;
  logic [DM_AW-1:0]  dm_addr;
  logic [7:0]        dm_rdata, dm_wdata, acc_value, tbl_high_byte;
  itd_phase_e        cycle_phase;
  int unsigned       bad_count, samples_checked, cyc;
  int unsigned       stamps[$];
  int unsigned       cost [17] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 1, 2, 2, 2, 1, 2, 2, 1};
  logic [7:0]        a, b, r, r2;
  logic [2:0]        k;
  logic [15:0]       tw;
  logic [8:0]        sum;

  itd_core DUT (.clk(clk), .resetn(resetn), .prog_addr(prog_addr), .prog_data(prog_data),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we),
    .wake_req(wake_req), .acc_value(acc_value), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .global_irq_enable(irq_en), .halted(halted),
    .tbl_high_byte(tbl_high_byte), .cycle_phase(cycle_phase), .instr_done(instr_done));
  itd_mem_model mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic put(input int adr, input itd_op_e op, input logic [2:0] f,
                     input logic [7:0] low);
    mem.prog[adr] = {op, f, low};
  endtask : put

  always #10 clk = ~clk;

  // Completion stamps give the cost of each executed instruction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (instr_done === 1'b1) begin
      stamps.push_back(cyc);
      check("dm_sector", {14'h0, dm_addr[9:8]}, 16'h0);
    end
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    wake_req = 1'b0;
    cyc = 0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(5));
    a = 8'($urandom);
    b = 8'($urandom);
    r = 8'($urandom);
    r2 = 8'($urandom);
    k = 3'($urandom);
    tw = 16'($urandom);
    sum = {1'b0, a} + {1'b0, b};
    foreach (mem.prog[i]) mem.prog[i] = 16'h0000;
    foreach (mem.data[i]) mem.data[i] = 8'h00;
    mem.data[18] = r;
    mem.data[21] = r2;
    mem.prog[1812] = tw;
    put(0, OP_XFER_A_X, 3'h1, a);
    put(1, OP_XFER_M_A, 3'h0, 8'h10);
    put(2, OP_XFER_A_X, 3'h1, b);
    put(3, OP_ADD, 3'h0, 8'h10);
    put(4, OP_XFER_M_A, 3'h0, 8'h11);
    put(5, OP_ADD_ONE, 3'h4, 8'h11);
    put(6, OP_ROT_LEFT, 3'h4, 8'h15);
    put(7, OP_BIT_SET, k, 8'h12);
    put(8, OP_CALL, 3'h0, 8'h0b);
    put(9, OP_UNCOND_BRANCH, 3'h0, 8'h0d);
    put(11, OP_AND, 3'h0, 8'h13);
    put(12, OP_SUB_EXIT, 3'h0, 8'h00);
    put(13, OP_SKIP_ZERO, 3'h0, 8'h13);
    for (int i = 14; i < 20; i++) put(i, OP_XFER_A_X, 3'h1, 8'hff);
    put(15, OP_XFER_A_X, 3'h1, 8'h14);
    put(16, OP_XFER_M_A, 3'h0, PC_LOW_BYTE_ADDR);
    put(20, OP_TABLE_READ, 3'h0, 8'h16);
    put(21, OP_POWER_DOWN, 3'h0, 8'h00);
    // Runs only after wake; pops the empty stack, so flow restarts at 0
    put(22, OP_INT_EXIT, 3'h0, 8'h00);
    repeat (16) @(posedge clk);
    check("phase_reset", {14'h0, cycle_phase}, 16'h0);
    #1 resetn = 1'b1;
    @(posedge clk);
    #1 check("phase_first", {14'h0, cycle_phase}, 16'h1);
    for (int n = 0; n < 400 && stamps.size() < 17; n++) @(posedge clk);
    if (stamps.size() < 17) begin
      bad_count++;
      report_and_stop();
    end
    // Gap after each op is four clocks per cycle it costs
    for (int i = 1; i < 17; i++) check("gap", 16'(stamps[i] - stamps[i-1]), 16'(PHASES * cost[i-1]));
    repeat (40) @(posedge clk);
    #1 check("op_count", 16'(stamps.size()), 16'd17);
    check("move", {8'h0, mem.data[16]}, {8'h0, a});
    check("inc", {8'h0, mem.data[17]}, {8'h0, sum[7:0] + 8'h01});
    check("carry", {15'h0, carry_flag}, {15'h0, sum[8]});
    check("rotate", {8'h0, mem.data[21]}, {8'h0, r2[6:0], r2[7]});
    check("bit_set", {8'h0, mem.data[18]}, {8'h0, r | (8'h01 << k)});
    check("zero", {15'h0, zero_flag}, 16'h1);
    check("acc", {8'h0, acc_value}, 16'h0014);
    check("pcl_mem", {8'h0, mem.data[6]}, 16'h0);
    check("tbl", {tbl_high_byte, mem.data[22]}, tw);
    check("halted", {15'h0, halted}, 16'h1);
    check("irq_en", {15'h0, irq_en}, 16'h0);
    wake_req = 1'b1;
    @(posedge clk);
    #1 wake_req = 1'b0;
    check("wake", {15'h0, halted}, 16'h0);
    repeat (8) @(posedge clk);
    #1 check("irq_exit", {15'h0, irq_en}, 16'h1);
    report_and_stop();
  end
endmodule : itd_core_bench
